// ==== spi_config_status_defines.vh ====
// Constants for the serial port configuration and status block.
// Assumes inclusion by bare name from the design file only.
`ifndef SPI_CONFIG_STATUS_DEFINES_VH
`define SPI_CONFIG_STATUS_DEFINES_VH

// ********************************************************************
// Register indices; the byte address is four times the index.
// ********************************************************************
`define CFG_INDEX      10'h0A1
`define RATE_INDEX     10'h0A2
`define DATA_INDEX     10'h0A3
`define CTRL_INDEX     10'h0F8

// ********************************************************************
// Configuration and status fields.
// ********************************************************************
`define CFG_BUSY_BIT   7
`define CFG_MASTER_ENABLE_BIT  6
`define CFG_PHASE_BIT  5
`define CFG_POL_BIT    4
`define CFG_SLAVE_SELECTED_FILTERED_BIT 3
`define CFG_NSSRAW_BIT 2
`define CFG_SHEMPT_BIT 1
`define CFG_RXEMPT_BIT 0

// ********************************************************************
// Control fields and reset values.
// ********************************************************************
`define CTRL_DONE_BIT  7
`define CTRL_WCOL_BIT  6
`define CTRL_MODF_BIT  5
`define CTRL_OVR_BIT   4
`define CTRL_MODE_HI   3
`define CTRL_MODE_LO   2
`define CTRL_TXEMPT_BIT 1
`define CTRL_EN_BIT    0
`define MODE_RESET     2'h1
`define MODE_3WIRE     2'h0
`define MODE_4WIRE     2'h1
`define RATE_RESET     8'h00

// ********************************************************************
// Receive buffer shape and byte length.
// ********************************************************************
`define RXF_DEPTH      8
`define RXF_AW         3
`define LAST_BIT       3'h7
`define LAST_HALF      4'hF
`endif

// ==== spi_config_status_register.v ====
// Serial port with its configuration and status register, an APB slave.
// Assumes pclk at 250 MHz; link pins come from another clock domain and
// the pad logic resolves each pin from its active-low output enable.
//
// Behaviour
// - Busy bit is one while any transfer runs, master or slave.
// - Master-enable one makes the port master; zero makes it slave.
// - Phase zero centres data on first clock edge; one on second.
// - Polarity zero idles clock low; one idles it high.
// - Slave-selected flag is one while select input is low.
// - Slave-selected flag comes from a de-glitched select input.
// - Raw select bit shows the unfiltered select level when read.
// - Slave shifter-empty sets when byte done and nothing pending.
// - Shifter-empty clears on load from transmit buffer or clock edge.
// - In master mode shifter-empty reads as one.
// - Slave receive-empty is one when read out, zero when unread.
// - In master mode receive-empty reads as one.
// - Slave samples master-out data in the centre of each bit.
// - Master samples slave-out data one cycle before bit end.
// - Select mode: 00 three-wire, 01 select input, 1x select output.
// - Four-wire slave clears its bit counter on select falling edge.
//
// Implementation choice: the APB slave port.
`include "spi_config_status_defines.vh"

// ********************************************************************
// Receive buffer.
// ********************************************************************
module rx_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage has no reset; only the pointers and the count need a known state.
    always @(posedge pclk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers wrap naturally because depth is a power of two.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// ********************************************************************
// Serial port top.
// ********************************************************************
module spi_config_status_register (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        sck_in,
    output wire        sck_out,
    output wire        sck_oe_n,
    input  wire        mosi_in,
    output wire        mosi_out,
    output wire        mosi_oe_n,
    input  wire        miso_in,
    output wire        miso_out,
    output wire        miso_oe_n,
    input  wire        slave_select_n_in,
    output wire        slave_select_n_out,
    output wire        slave_select_n_oe_n
);
    localparam M_IDLE = 2'b01;
    localparam M_RUN  = 2'b10;

    reg  [3:0] sync1;
    reg  [3:0] sync2;
    reg        sck_d;
    reg        nss_d;
    reg        nss_filt;
    reg        nss_filt_d;
    reg        master_enable;
    reg        clock_phase_sel;
    reg        clock_polarity_sel;
    reg  [1:0] slave_select_mode;
    reg        port_enable;
    reg        done_flag;
    reg        wcol_flag;
    reg        modf_flag;
    reg        ovr_flag;
    reg  [7:0] rate;
    reg  [7:0] tx_buf;
    reg        tx_full;
    reg  [7:0] shifter;
    reg        out_bit;
    reg        shifter_empty_r;
    reg  [2:0] bit_cnt;
    reg        slave_active;
    reg  [1:0] m_state;
    reg  [3:0] half_cnt;
    reg  [7:0] div_cnt;
    reg        sck_drv;
    reg        rx_push;
    reg  [7:0] rx_byte;
    wire       sck_s;
    wire       mosi_s;
    wire       miso_s;
    wire       slave_select_raw;
    wire       slave_selected_filtered;
    wire       is_master;
    wire       selected;
    wire       slave_on;
    wire       sck_edge;
    wire       lead_edge;
    wire       sample_edge;
    wire       shift_edge;
    wire       nss_fall;
    wire       transfer_busy;
    wire       shifter_empty;
    wire       rx_buffer_empty;
    wire       rx_ready;
    wire       rx_valid;
    wire [7:0] rx_data;
    wire       setup;
    wire       access;
    wire       hit_cfg;
    wire       hit_rate;
    wire       hit_data;
    wire       hit_ctrl;
    wire       mapped;
    wire       wr;
    wire       rd_data;
    wire       half_end;
    wire [7:0] cfg_val;
    wire [7:0] ctrl_val;
    wire [3:0] pins;

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    assign pins = {slave_select_n_in, miso_in, mosi_in, sck_in};

    // Each link pin passes two flops before any logic reads it.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : pin_sync
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1[g] <= 1'b1;
                    sync2[g] <= 1'b1;
                end
                else
                begin
                    sync1[g] <= pins[g];
                    sync2[g] <= sync1[g];
                end
            end
        end
    endgenerate

    assign sck_s            = sync2[0];
    assign mosi_s           = sync2[1];
    assign miso_s           = sync2[2];
    assign slave_select_raw = sync2[3];

    // The select filter only follows a level that held for two samples,
    // so a one-cycle glitch never reaches the selected flag.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_d      <= 1'b0;
            nss_d      <= 1'b1;
            nss_filt   <= 1'b1;
            nss_filt_d <= 1'b1;
        end
        else
        begin
            sck_d      <= sck_s;
            nss_d      <= slave_select_raw;
            if (nss_d == slave_select_raw)
                nss_filt <= nss_d;
            nss_filt_d <= nss_filt;
        end
    end

    // ****************************************************************
    // Mode decode and status.
    // ****************************************************************
    assign slave_selected_filtered = !nss_filt;
    assign is_master   = master_enable;
    assign selected    = (slave_select_mode == `MODE_4WIRE) ?
                         slave_selected_filtered : 1'b1;
    assign slave_on    = port_enable && !is_master && selected;
    assign sck_edge    = (sck_s != sck_d) && slave_on;
    assign lead_edge   = sck_edge && (sck_d == clock_polarity_sel);
    assign sample_edge = clock_phase_sel ? (sck_edge && !lead_edge)
                                         : lead_edge;
    assign shift_edge  = sck_edge && !sample_edge;
    assign nss_fall    = nss_filt_d && !nss_filt &&
                         (slave_select_mode == `MODE_4WIRE);
    assign transfer_busy = (m_state == M_RUN) || slave_active;
    assign shifter_empty = is_master ? 1'b1 : shifter_empty_r;
    assign rx_buffer_empty = is_master ? 1'b1 : !rx_valid;
    assign half_end    = (m_state == M_RUN) && (div_cnt == rate);

    assign cfg_val  = {transfer_busy, master_enable, clock_phase_sel,
                       clock_polarity_sel, slave_selected_filtered,
                       slave_select_raw, shifter_empty, rx_buffer_empty};
    assign ctrl_val = {done_flag, wcol_flag, modf_flag, ovr_flag,
                       slave_select_mode, !tx_full, port_enable};

    // ****************************************************************
    // Link pins.
    // ****************************************************************
    // Clock idles at the polarity level whenever no transfer runs.
    assign sck_out   = (m_state == M_RUN) ? sck_drv
                                          : clock_polarity_sel;
    assign sck_oe_n  = !(port_enable && is_master);
    assign mosi_out  = out_bit;
    assign mosi_oe_n = !(port_enable && is_master);
    assign miso_out  = out_bit;
    assign miso_oe_n = !slave_on;
    assign slave_select_n_out  = slave_select_mode[0];
    assign slave_select_n_oe_n = !slave_select_mode[1];

    // ****************************************************************
    // APB decode.
    // ****************************************************************
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign hit_cfg  = (paddr[11:2] == `CFG_INDEX);
    assign hit_rate = (paddr[11:2] == `RATE_INDEX);
    assign hit_data = (paddr[11:2] == `DATA_INDEX);
    assign hit_ctrl = (paddr[11:2] == `CTRL_INDEX);
    assign mapped   = (paddr[1:0] == 2'h0) &&
                      (hit_cfg || hit_rate || hit_data || hit_ctrl);
    assign pready   = 1'b1;
    assign pslverr  = access && !mapped;
    assign wr       = access && pwrite && mapped;
    assign rd_data  = access && !pwrite && mapped && hit_data;

    // Read data is captured in the setup cycle so it comes from a flop;
    // the raw select bit is therefore the level seen at that edge.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (setup && !pwrite && (paddr[1:0] == 2'h0))
        begin
            if (hit_cfg)
                prdata <= {24'h000000, cfg_val};
            else if (hit_rate)
                prdata <= {24'h000000, rate};
            else if (hit_data)
                prdata <= {24'h000000, rx_data};
            else if (hit_ctrl)
                prdata <= {24'h000000, ctrl_val};
            else
                prdata <= 32'h00000000;
        end
    end

    // ****************************************************************
    // Registers, master sequencer and slave shifter.
    // ****************************************************************
    // One process owns the shared shifter so master and slave never
    // fight over it; hardware-set flags win over a software clear.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            master_enable      <= 1'b0;
            clock_phase_sel    <= 1'b0;
            clock_polarity_sel <= 1'b0;
            slave_select_mode  <= `MODE_RESET;
            port_enable        <= 1'b0;
            done_flag          <= 1'b0;
            wcol_flag          <= 1'b0;
            modf_flag          <= 1'b0;
            ovr_flag           <= 1'b0;
            rate               <= `RATE_RESET;
            tx_buf             <= 8'h00;
            tx_full            <= 1'b0;
            shifter            <= 8'h00;
            out_bit            <= 1'b0;
            shifter_empty_r    <= 1'b1;
            bit_cnt            <= 3'h0;
            slave_active       <= 1'b0;
            m_state            <= M_IDLE;
            half_cnt           <= 4'h0;
            div_cnt            <= 8'h00;
            sck_drv            <= 1'b0;
            rx_push            <= 1'b0;
            rx_byte            <= 8'h00;
        end
        else
        begin
            rx_push <= 1'b0;
            // Software writes; flag bits clear only when written zero.
            if (wr && hit_cfg)
            begin
                master_enable      <= pwdata[`CFG_MASTER_ENABLE_BIT];
                clock_phase_sel    <= pwdata[`CFG_PHASE_BIT];
                clock_polarity_sel <= pwdata[`CFG_POL_BIT];
            end
            if (wr && hit_rate)
                rate <= pwdata[7:0];
            if (wr && hit_ctrl)
            begin
                done_flag <= done_flag & pwdata[`CTRL_DONE_BIT];
                wcol_flag <= wcol_flag & pwdata[`CTRL_WCOL_BIT];
                modf_flag <= modf_flag & pwdata[`CTRL_MODF_BIT];
                ovr_flag  <= ovr_flag & pwdata[`CTRL_OVR_BIT];
                slave_select_mode <= pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
                port_enable <= pwdata[`CTRL_EN_BIT];
            end
            if (wr && hit_data)
            begin
                if (tx_full)
                    wcol_flag <= 1'b1;
                else
                begin
                    tx_buf  <= pwdata[7:0];
                    tx_full <= 1'b1;
                end
            end
            // Another master pulled select low while we were master.
            if (port_enable && is_master && slave_selected_filtered &&
                (slave_select_mode == `MODE_4WIRE))
            begin
                modf_flag     <= 1'b1;
                master_enable <= 1'b0;
                port_enable   <= 1'b0;
            end
            if (!port_enable)
            begin
                bit_cnt      <= 3'h0;
                slave_active <= 1'b0;
                m_state      <= M_IDLE;
            end
            else if (is_master)
            begin
                case (m_state)
                    M_IDLE:
                    begin
                        if (tx_full)
                        begin
                            shifter  <= tx_buf;
                            out_bit  <= tx_buf[7];
                            tx_full  <= 1'b0;
                            half_cnt <= 4'h0;
                            div_cnt  <= 8'h00;
                            // Second-edge phase makes its lead edge now.
                            sck_drv  <= clock_polarity_sel ^
                                        clock_phase_sel;
                            m_state  <= M_RUN;
                        end
                    end
                    M_RUN:
                    begin
                        if (half_end)
                        begin
                            div_cnt  <= 8'h00;
                            half_cnt <= half_cnt + 1'b1;
                            if (!clock_phase_sel ||
                                (half_cnt != `LAST_HALF))
                                sck_drv <= !sck_drv;
                            if (half_cnt[0])
                            begin
                                // Last cycle of the bit: sample input.
                                shifter <= {shifter[6:0], miso_s};
                                out_bit <= shifter[6];
                            end
                            if (half_cnt == `LAST_HALF)
                            begin
                                rx_byte   <= {shifter[6:0], miso_s};
                                rx_push   <= 1'b1;
                                done_flag <= 1'b1;
                                m_state   <= M_IDLE;
                            end
                        end
                        else
                            div_cnt <= div_cnt + 1'b1;
                    end
                    default:
                        m_state <= M_IDLE;
                endcase
            end
            else
            begin
                m_state <= M_IDLE;
                if (nss_fall)
                begin
                    bit_cnt      <= 3'h0;
                    slave_active <= 1'b0;
                    shifter_empty_r <= 1'b1;
                end
                else if (sample_edge)
                begin
                    // Sample edge sits mid-bit for either phase.
                    shifter      <= {shifter[6:0], mosi_s};
                    slave_active <= 1'b1;
                    bit_cnt      <= bit_cnt + 1'b1;
                    if (bit_cnt == `LAST_BIT)
                    begin
                        rx_byte      <= {shifter[6:0], mosi_s};
                        rx_push      <= 1'b1;
                        done_flag    <= 1'b1;
                        slave_active <= 1'b0;
                        if (!rx_ready)
                            ovr_flag <= 1'b1;
                        if (tx_full)
                        begin
                            shifter <= tx_buf;
                            out_bit <= tx_buf[7];
                            tx_full <= 1'b0;
                        end
                        else
                            shifter_empty_r <= 1'b1;
                    end
                    else
                        shifter_empty_r <= 1'b0;
                end
                // The edge after a phase-zero byte's last sample shifts nothing.
                else if (shift_edge && (clock_phase_sel || bit_cnt != 3'h0))
                begin
                    out_bit         <= shifter[7];
                    slave_active    <= 1'b1;
                    shifter_empty_r <= 1'b0;
                end
                else if (tx_full && shifter_empty_r)
                begin
                    // Idle shifter takes a fresh byte at once.
                    shifter         <= tx_buf;
                    out_bit         <= tx_buf[7];
                    tx_full         <= 1'b0;
                    shifter_empty_r <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Receive buffer instance.
    // ****************************************************************
    // A full buffer refuses the byte, which is then lost; only a slave byte also sets overrun.
    rx_fifo #(
        .WIDTH (8),
        .DEPTH (`RXF_DEPTH),
        .AW    (`RXF_AW)
    ) u_rx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   (rx_byte),
        .in_valid  (rx_push),
        .in_ready  (rx_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rd_data)
    );
endmodule

// ==== spi_config_status_register_asserts.sv ====
// Checker for the serial port's bus face and pin enables.
// Assumes it is bound to the top module and sees only its ports.
module spi_config_status_register_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sck_oe_n,
    input wire logic        mosi_oe_n,
    input wire logic        miso_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Only the four register words answer without an error.
    wire mapped = paddr == 12'h284 || paddr == 12'h288 ||
                  paddr == 12'h28C || paddr == 12'h3E0;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_unmapped: assert property
        (setup_s ##1 access_s ##0 !mapped |-> pslverr)
        else $error("no error on unmapped access");
    chk_err_mapped: assert property (access_s ##0 mapped |-> !pslverr)
        else $error("error on mapped access");
    chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access");
    chk_rdata_upper: assert property (prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    // Read data may move only after a read setup edge.
    chk_rdata_hold: assert property
        (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    chk_master_pins: assert property (sck_oe_n == mosi_oe_n)
        else $error("clock and data drive differ");
    chk_miso_slave: assert property (!sck_oe_n |-> miso_oe_n)
        else $error("master drives slave data");
endmodule

bind spi_config_status_register spi_config_status_register_asserts u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .sck_oe_n, .mosi_oe_n, .miso_oe_n);

// ==== link_slave.sv ====
// Behavioural far-end slave used while the port is master.
// Assumes clock, data and select arrive as resolved pin levels.
module link_slave (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] tx_byte,
    output      logic       miso,
    output      logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh = 8'h00;
    // Selection loads the byte; phase zero shows its top bit at once.
    always @(negedge sel_n)
    begin
        sh = tx_byte;
        miso = tx_byte[7];
    end
    // A released line shows the inverse of its last level.
    always @(posedge sel_n)
        miso = ~miso;
    // Leading edge samples for phase zero, trailing edge for phase one.
    always @(sck)
    begin
        if (!sel_n && ((sck ^ cpol) != cpha))
            rx_byte = {rx_byte[6:0], mosi};
        else if (!sel_n && cpha)
        begin
            miso = sh[7];
            sh = sh << 1;
        end
        else if (!sel_n)
        begin
            sh = sh << 1;
            miso = sh[7];
        end
    end
endmodule

// ==== spi_config_status_register_tb.sv ====
// Self-checking bench for the serial port configuration register.
// Assumes the design, its bound checker and the far-end slave model.
module spi_config_status_register_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] CFG = 12'h284;
    localparam logic [11:0] DATA = 12'h28C;
    localparam logic [11:0] CTRL = 12'h3E0;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, sck_out, sck_oe_n, mosi_out, mosi_oe_n;
    logic        miso_out, miso_oe_n, ssn_out, ssn_oe_n, p_miso;
    logic        sck_tb = 1'b0, mosi_tb = 1'b0, ssn = 1'b1;
    logic        cpha = 1'b0, cpol = 1'b0;
    logic [7:0]  p_tx = 8'h00, p_rx, got;
    int          failures = 0, comparisons = 0, cycles = 0;
    // Each pin takes the level of whichever party drives it.
    wire sck = sck_oe_n ? sck_tb : sck_out;
    wire mosi = mosi_oe_n ? mosi_tb : mosi_out;
    wire miso = miso_oe_n ? p_miso : miso_out;
    wire ssn_pin = ssn_oe_n ? ssn : ssn_out;
    spi_config_status_register u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sck_in(sck), .sck_out, .sck_oe_n,
        .mosi_in(mosi), .mosi_out, .mosi_oe_n, .miso_in(miso), .miso_out,
        .miso_oe_n, .slave_select_n_in(ssn_pin),
        .slave_select_n_out(ssn_out), .slave_select_n_oe_n(ssn_oe_n));
    link_slave u_far (.sck, .mosi, .sel_n(ssn_pin), .cpol, .cpha,
        .tx_byte(p_tx), .miso(p_miso), .rx_byte(p_rx));
    always #2 pclk = ~pclk;
    // A hang ends the run as a failure rather than stalling it.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [31:0] e, s);
        comparisons++;
        if (s !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Link master for slave mode; its clock is unrelated to pclk.
    task automatic bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            mosi_tb = b[i];
            #31.5 sck_tb = 1'b1;
            got[i] = miso;
            #62.5 sck_tb = 1'b0;
            #31;
        end
    endtask
    task automatic tally_and_finish();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CFG, 0);
        check("config reset", 32'h07, rd);
        apb(0, CTRL, 0);
        check("control reset", 32'h06, rd);
        apb(0, 12'h290, 0);
        check("unmapped error", 1'b1, err);
        apb(1, CTRL, 8'h05);
        apb(1, CFG, 8'h00);
        ssn = 1'b0;
        repeat (10) @(posedge pclk);
        apb(0, CFG, 0);
        check("config selected", 32'h0B, rd);
        bits(8'hFF, 3);
        ssn = 1'b1;
        #100 ssn = 1'b0;
        #100 apb(1, DATA, 8'h5A);
        apb(0, CFG, 0);
        check("shifter loaded", 1'b0, rd[1]);
        fork
            bits(8'hC3, 8);
            #500 apb(0, CFG, 0);
        join
        check("busy mid byte", 1'b1, rd[7]);
        check("slave sent", 8'h5A, got);
        #100 apb(0, CFG, 0);
        check("config after byte", 32'h0A, rd);
        apb(0, DATA, 0);
        check("slave received", 8'hC3, rd);
        apb(0, CFG, 0);
        check("rx empty again", 1'b1, rd[0]);
        ssn = 1'b1;
        apb(1, 12'h288, 8'h01);
        apb(1, CTRL, 8'h0D);
        for (int k = 0; k < 4; k++)
        begin
            {cpha, cpol} = k[1:0];
            p_tx = 8'h96 + k[7:0];
            apb(1, CFG, {2'b01, cpha, cpol, 4'h0});
            apb(1, CTRL, 8'h09);
            @(posedge pclk);
            check("idle clock", cpol, sck);
            apb(1, DATA, 8'h3C ^ k[7:0]);
            for (int n = 0; n < 99 && (n == 0 || rd[7]); n++)
                apb(0, CFG, 0);
            check("far end received", 8'h3C ^ k[7:0], p_rx);
            apb(0, DATA, 0);
            check("master received", p_tx, rd);
            apb(0, CFG, 0);
            check("master config", {2'b01, cpha, cpol, 4'hB}, rd);
            apb(1, CTRL, 8'h0D);
        end
        tally_and_finish();
    end
endmodule
